// file: design/tws_map.svh
// Constants of the two-wire slave protocol engine: codes, addresses, masks, timing.
// Assumes inclusion by bare name from the package and the engine.
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

`define TWS_ID_ARRAY 4'hA
`define TWS_ID_REGS 4'hD
`define TWS_SELECT 3'h7
`define TWS_SR_ADDR 16'h003F
`define TWS_SR_SET_WEL 8'h02
`define TWS_SR_SET_BOTH 8'h06
`define TWS_SR_CLEAR 8'h00
`define TWS_ADDR_RESET 16'h0000
`define TWS_ARR_MASK 16'h07FF
`define TWS_REG_MASK 16'h003F
`define TWS_ARR_PG_MASK 16'h003F
`define TWS_REG_PG_MASK 16'h0007
`define TWS_BUF_DEPTH 64
`define TWS_BUF_END 7'h40
`define TWS_BITS_BYTE 4'h8
`define TWS_WR_TIME_US 5000
`define TWS_CORE_MHZ 40

`endif

// file: design/tws_pkg.sv
// Types of the two-wire slave protocol engine.
// Assumes tws_map.svh is on the include path.
`include "tws_map.svh"

package tws_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_RX    = 3'h1,
        ST_ACK   = 3'h2,
        ST_TX    = 3'h3,
        ST_MACK  = 3'h4,
        ST_FLUSH = 3'h5,
        ST_BUSY  = 3'h6
    } tws_state_t;

    typedef enum logic [1:0] {
        OP_READ   = 2'h0,
        OP_WRITE  = 2'h1,
        OP_COMMIT = 2'h2
    } tws_op_t;

    // Memory request handed from the link domain to the core domain
    typedef struct packed {
        tws_op_t op;
        logic space;
        logic [15:0] addr;
        logic [7:0] wdata;
    } tws_req_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic prot_s1;
        logic prot_s2;
        logic ack_s1;
        logic ack_s2;
        logic scl_d;
        logic sda_d;
        tws_state_t state;
        logic [1:0] phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rd;
        logic space;
        logic sr_hit;
        logic data_seen;
        logic sda_oe;
        logic [15:0] ctr;
        logic [15:0] base;
        logic write_enable_latch;
        logic register_write_latch;
        logic [`TWS_BUF_DEPTH-1:0][7:0] buffer;
        logic [`TWS_BUF_DEPTH-1:0] vld;
        logic [6:0] idx;
        tws_req_t req;
        logic req_tog;
    } tws_link_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_tog;
        logic rd_pend;
        logic busy;
        logic [31:0] cnt;
        logic [7:0] rdata;
        logic mem_we;
        logic mem_re;
        logic mem_space;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
    } tws_core_t;

endpackage

// file: design/tws_slave.sv
// Two-wire slave protocol engine: bus side on the link clock, memory side on the core clock.
// Assumes an asynchronous-read memory outside (data valid in the same core cycle as o_mem_re)
// and an external pull-up that resolves SDA from o_sda_oe.
`timescale 1ns/1ps
`include "tws_map.svh"

module tws_slave #(
    parameter int unsigned WR_CYCLES = `TWS_WR_TIME_US * `TWS_CORE_MHZ
) (
    // Clocks, reset, enable
    input wire logic i_core_clk,
    input wire logic i_link_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Two-wire bus
    input wire logic i_scl,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Protection and status
    input wire logic i_wr_protect,
    output logic o_write_enable_latch,
    output logic o_register_write_latch,
    output logic o_busy,
    // Memory port, core domain
    output logic o_mem_we,
    output logic o_mem_re,
    output logic o_mem_space,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic [7:0] i_mem_rdata
);

    tws_pkg::tws_link_t l_r;
    tws_pkg::tws_link_t l_nxt;
    tws_pkg::tws_core_t c_r;
    tws_pkg::tws_core_t c_nxt;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic pending;
    logic [15:0] pg_mask;
    logic [15:0] sp_mask;
    logic [15:0] wr_next;
    logic [5:0] buf_idx;
    logic id_ok;
    logic allow;
    logic [7:0] tx_byte;
    logic [7:0] sr_byte;

    // Link domain
    always_comb begin
        l_nxt = l_r;
        l_nxt.scl_s1 = i_scl;
        l_nxt.scl_s2 = l_r.scl_s1;
        l_nxt.sda_s1 = i_sda_i;
        l_nxt.sda_s2 = l_r.sda_s1;
        l_nxt.prot_s1 = i_wr_protect;
        l_nxt.prot_s2 = l_r.prot_s1;
        l_nxt.ack_s1 = c_r.ack_tog;
        l_nxt.ack_s2 = l_r.ack_s1;
        l_nxt.scl_d = l_r.scl_s2;
        l_nxt.sda_d = l_r.sda_s2;

        scl_rise = l_r.scl_s2 & ~l_r.scl_d;
        scl_fall = ~l_r.scl_s2 & l_r.scl_d;
        bus_start = l_r.scl_s2 & l_r.scl_d & l_r.sda_d & ~l_r.sda_s2;
        bus_stop = l_r.scl_s2 & l_r.scl_d & ~l_r.sda_d & l_r.sda_s2;
        pending = l_r.req_tog != l_r.ack_s2;

        pg_mask = l_r.space ? `TWS_REG_PG_MASK : `TWS_ARR_PG_MASK;
        sp_mask = l_r.space ? `TWS_REG_MASK : `TWS_ARR_MASK;
        wr_next = (l_r.ctr & ~pg_mask) | ((l_r.ctr + 16'h0001) & pg_mask);
        buf_idx = 6'(l_r.ctr & pg_mask);
        id_ok = (l_r.shreg[7:4] == `TWS_ID_ARRAY || l_r.shreg[7:4] == `TWS_ID_REGS)
            && l_r.shreg[3:1] == `TWS_SELECT;
        allow = l_r.sr_hit ? ~l_r.data_seen
            : (l_r.write_enable_latch && (~l_r.space || l_r.register_write_latch));
        tx_byte = (l_r.space && l_r.ctr == `TWS_SR_ADDR)
            ? {5'h00, l_r.register_write_latch, l_r.write_enable_latch, 1'b0} : c_r.rdata;
        // Stop's own SCL rise has shifted shreg, so use the stored byte
        sr_byte = l_r.buffer[6'(`TWS_SR_ADDR & `TWS_REG_PG_MASK)];

        // Inputs stay disabled while the page is flushed and the cycle runs
        if (l_r.state == tws_pkg::ST_FLUSH) begin
            l_nxt.sda_oe = 1'b0;
            if (!pending) begin
                if (l_r.idx == `TWS_BUF_END) begin
                    l_nxt.req = '{op: tws_pkg::OP_COMMIT, space: l_r.space,
                        addr: l_r.base, wdata: 8'h00};
                    l_nxt.req_tog = ~l_r.req_tog;
                    l_nxt.state = tws_pkg::ST_BUSY;
                end else begin
                    if (l_r.vld[l_r.idx[5:0]]) begin
                        l_nxt.req = '{op: tws_pkg::OP_WRITE, space: l_r.space,
                            addr: l_r.base | {10'h000, l_r.idx[5:0]},
                            wdata: l_r.buffer[l_r.idx[5:0]]};
                        l_nxt.req_tog = ~l_r.req_tog;
                    end
                    l_nxt.idx = l_r.idx + 7'h01;
                end
            end
        end else if (l_r.state == tws_pkg::ST_BUSY) begin
            l_nxt.sda_oe = 1'b0;
            if (!pending) begin
                l_nxt.state = tws_pkg::ST_IDLE;
                if (l_r.space) begin
                    l_nxt.register_write_latch = 1'b0;
                end
            end
        end else if (bus_start) begin
            l_nxt.state = tws_pkg::ST_RX;
            l_nxt.phase = 2'h0;
            l_nxt.bitcnt = 4'h0;
            l_nxt.sda_oe = 1'b0;
            l_nxt.data_seen = 1'b0;
            l_nxt.vld = '0;
        end else if (bus_stop) begin
            l_nxt.state = tws_pkg::ST_IDLE;
            l_nxt.sda_oe = 1'b0;
            // Only a stop on a byte boundary after an accepted byte commits
            // Every stop follows one SCL rise, so one counted bit is a boundary
            if (!l_r.rd && l_r.phase == 2'h3 && l_r.state == tws_pkg::ST_RX
                && l_r.bitcnt <= 4'h1 && l_r.data_seen) begin
                if (l_r.sr_hit) begin
                    // Volatile latches need no write cycle
                    if (sr_byte == `TWS_SR_SET_WEL) begin
                        l_nxt.write_enable_latch = 1'b1;
                    end else if (sr_byte == `TWS_SR_SET_BOTH && l_r.write_enable_latch) begin
                        l_nxt.register_write_latch = 1'b1;
                    end else if (sr_byte == `TWS_SR_CLEAR) begin
                        l_nxt.write_enable_latch = 1'b0;
                        l_nxt.register_write_latch = 1'b0;
                    end
                end else if (l_r.space || !l_r.prot_s2) begin
                    l_nxt.state = tws_pkg::ST_FLUSH;
                    l_nxt.idx = 7'h00;
                end
            end
        end else begin
            case (l_r.state)
                tws_pkg::ST_RX: begin
                    if (scl_rise) begin
                        l_nxt.shreg = {l_r.shreg[6:0], l_r.sda_s2};
                        l_nxt.bitcnt = l_r.bitcnt + 4'h1;
                    end else if (scl_fall && l_r.bitcnt == `TWS_BITS_BYTE) begin
                        l_nxt.bitcnt = 4'h0;
                        l_nxt.state = tws_pkg::ST_ACK;
                        l_nxt.sda_oe = 1'b1;
                        case (l_r.phase)
                            2'h0: begin
                                if (!id_ok) begin
                                    l_nxt.state = tws_pkg::ST_IDLE;
                                    l_nxt.sda_oe = 1'b0;
                                end else begin
                                    l_nxt.space = l_r.shreg[7:4] == `TWS_ID_REGS;
                                    l_nxt.rd = l_r.shreg[0];
                                    l_nxt.phase = l_r.shreg[0] ? 2'h0 : 2'h1;
                                    if (l_r.shreg[0]) begin
                                        l_nxt.req = '{op: tws_pkg::OP_READ,
                                            space: l_r.shreg[7:4] == `TWS_ID_REGS,
                                            addr: l_r.ctr, wdata: 8'h00};
                                        l_nxt.req_tog = ~l_r.req_tog;
                                    end
                                end
                            end
                            2'h1: begin
                                l_nxt.ctr = {l_r.shreg, l_r.ctr[7:0]};
                                l_nxt.phase = 2'h2;
                            end
                            2'h2: begin
                                // Counter loads here, so a stop now sets the address
                                l_nxt.ctr = {l_r.ctr[15:8], l_r.shreg};
                                l_nxt.base = {l_r.ctr[15:8], l_r.shreg} & ~pg_mask;
                                l_nxt.sr_hit = l_r.space
                                    && {l_r.ctr[15:8], l_r.shreg} == `TWS_SR_ADDR;
                                l_nxt.phase = 2'h3;
                            end
                            default: begin
                                if (allow) begin
                                    l_nxt.buffer[buf_idx] = l_r.shreg;
                                    l_nxt.vld[buf_idx] = 1'b1;
                                    l_nxt.data_seen = 1'b1;
                                    l_nxt.ctr = wr_next;
                                end else begin
                                    l_nxt.state = tws_pkg::ST_IDLE;
                                    l_nxt.sda_oe = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                tws_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        l_nxt.sda_oe = 1'b0;
                        l_nxt.state = l_r.rd ? tws_pkg::ST_TX : tws_pkg::ST_RX;
                    end
                end
                tws_pkg::ST_TX: begin
                    if (l_r.bitcnt == 4'h0) begin
                        // Wait for the fetch; SCL low leaves ample time for it
                        if (!pending) begin
                            l_nxt.shreg = tx_byte;
                            l_nxt.sda_oe = ~tx_byte[7];
                            l_nxt.bitcnt = 4'h1;
                            l_nxt.ctr = (l_r.ctr + 16'h0001) & sp_mask;
                        end
                    end else if (scl_fall) begin
                        if (l_r.bitcnt == `TWS_BITS_BYTE) begin
                            l_nxt.sda_oe = 1'b0;
                            l_nxt.bitcnt = 4'h0;
                            l_nxt.state = tws_pkg::ST_MACK;
                        end else begin
                            l_nxt.sda_oe = ~l_r.shreg[6];
                            l_nxt.shreg = {l_r.shreg[6:0], 1'b0};
                            l_nxt.bitcnt = l_r.bitcnt + 4'h1;
                        end
                    end
                end
                tws_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        if (!l_r.sda_s2) begin
                            l_nxt.req = '{op: tws_pkg::OP_READ, space: l_r.space,
                                addr: l_r.ctr, wdata: 8'h00};
                            l_nxt.req_tog = ~l_r.req_tog;
                            l_nxt.bitcnt = 4'h1;
                        end else begin
                            l_nxt.state = tws_pkg::ST_IDLE;
                        end
                    end else if (scl_fall && l_r.bitcnt == 4'h1) begin
                        l_nxt.bitcnt = 4'h0;
                        l_nxt.state = tws_pkg::ST_TX;
                    end
                end
                default: begin
                    l_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            l_r <= '0;
            l_r.ctr <= `TWS_ADDR_RESET;
        end else if (i_ce) begin
            l_r <= l_nxt;
        end
    end

    // Core domain; request fields are stable while the toggles differ
    always_comb begin
        c_nxt = c_r;
        c_nxt.req_s1 = l_r.req_tog;
        c_nxt.req_s2 = c_r.req_s1;
        c_nxt.mem_we = 1'b0;
        c_nxt.mem_re = 1'b0;
        if (c_r.rd_pend) begin
            c_nxt.rdata = i_mem_rdata;
            c_nxt.rd_pend = 1'b0;
            c_nxt.ack_tog = ~c_r.ack_tog;
        end else if (c_r.busy) begin
            if (c_r.cnt == 32'h0000_0000) begin
                c_nxt.busy = 1'b0;
                c_nxt.ack_tog = ~c_r.ack_tog;
            end else begin
                c_nxt.cnt = c_r.cnt - 32'h0000_0001;
            end
        end else if (c_r.req_s2 != c_r.req_seen) begin
            c_nxt.req_seen = c_r.req_s2;
            c_nxt.mem_space = l_r.req.space;
            c_nxt.mem_addr = l_r.req.addr;
            c_nxt.mem_wdata = l_r.req.wdata;
            case (l_r.req.op)
                tws_pkg::OP_READ: begin
                    c_nxt.mem_re = 1'b1;
                    c_nxt.rd_pend = 1'b1;
                end
                tws_pkg::OP_WRITE: begin
                    c_nxt.mem_we = 1'b1;
                    c_nxt.ack_tog = ~c_r.ack_tog;
                end
                tws_pkg::OP_COMMIT: begin
                    c_nxt.busy = 1'b1;
                    c_nxt.cnt = 32'(WR_CYCLES - 1);
                end
                default: begin
                    c_nxt.ack_tog = ~c_r.ack_tog;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            c_r <= '0;
        end else if (i_ce) begin
            c_r <= c_nxt;
        end
    end

    // Open drain: only ever pulls low
    assign o_sda_o = 1'b0;
    assign o_sda_oe = l_r.sda_oe;
    assign o_write_enable_latch = l_r.write_enable_latch;
    assign o_register_write_latch = l_r.register_write_latch;
    assign o_busy = c_r.busy;
    assign o_mem_we = c_r.mem_we;
    assign o_mem_re = c_r.mem_re;
    assign o_mem_space = c_r.mem_space;
    assign o_mem_addr = c_r.mem_addr;
    assign o_mem_wdata = c_r.mem_wdata;

endmodule

// file: tb/tws_chk.sv
// Checker: port assertions for the two-wire slave engine.
// Assumes a bind into tws_slave that hands on its write-cycle count.
`timescale 1ns/1ps
module tws_chk #(
    parameter int unsigned WR_CYCLES = 20
) (
    // Clocks and reset
    input wire logic i_core_clk,
    input wire logic i_link_clk,
    input wire logic i_rst,
    // Bus and protection
    input wire logic i_scl,
    input wire logic i_wr_protect,
    input wire logic o_sda_oe,
    // Status and memory
    input wire logic o_write_enable_latch,
    input wire logic o_register_write_latch,
    input wire logic o_busy,
    input wire logic o_mem_we,
    input wire logic o_mem_space
);
    // Counter, since the cycle is far longer than a repetition may be
    logic [31:0] busy_len_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_len_r <= 32'h0;
        end else begin
            busy_len_r <= o_busy ? busy_len_r + 32'h1 : 32'h0;
        end
    end
    a_busy_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_busy) |-> busy_len_r + 32'h1 >= WR_CYCLES && busy_len_r <= WR_CYCLES + 32'h1)
        else $error("write cycle length wrong");
    a_busy_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_busy |-> !o_sda_oe) else $error("bus driven while busy");
    a_we_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_mem_we |-> o_write_enable_latch) else $error("write without enable");
    a_we_reg: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_mem_we && o_mem_space |-> o_register_write_latch) else $error("register write locked");
    a_we_protect: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_mem_we && !o_mem_space |-> !i_wr_protect) else $error("protected write");
    a_we_to_busy: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_mem_we |-> ##[0:1000] o_busy) else $error("no write cycle after load");
    a_oe_rise_low: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $rose(o_sda_oe) |-> !i_scl) else $error("data pulled while clock high");
    a_oe_fall_low: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $fell(o_sda_oe) |-> !i_scl) else $error("data released while clock high");
    c_busy: cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_busy));
    c_we: cover property (@(posedge i_core_clk) disable iff (i_rst) o_mem_we && o_mem_space);
    c_ack: cover property (@(posedge i_link_clk) disable iff (i_rst) $rose(o_sda_oe));
endmodule

bind tws_slave tws_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (.i_core_clk, .i_link_clk, .i_rst,
    .i_scl, .i_wr_protect, .o_sda_oe, .o_write_enable_latch, .o_register_write_latch,
    .o_busy, .o_mem_we, .o_mem_space);

// file: tb/tws_master.sv
// Bus master model: drives SCL and its side of SDA, samples the wired line.
// Assumes a pull-up on SDA, so a released master side reads as one.
`timescale 1ns/1ps
module tws_master #(
    parameter int Q = 8
) (
    // Timing
    input wire logic i_clk,
    // Bus
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic q();
        repeat (Q) @(negedge i_clk);
    endtask
    // Also serves as repeated start: SDA rises while SCL low
    task automatic start();
        o_sda = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda = 1'b0;
        q();
        o_scl = 1'b0;
        q();
    endtask
    task automatic stop();
        o_sda = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda = 1'b1;
        q();
    endtask
    task automatic bit_io(input logic b, output logic r);
        o_sda = b;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
        q();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// file: tb/tws_slave_tb_top.sv
// Testbench: master model and memory model around the two-wire slave engine.
// Assumes tws_master and tws_chk are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tws_slave_tb_top;
    logic i_core_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_rst = 1'b1;
    logic prot = 1'b0;
    logic scl, sda_m, sda_oe, we_latch, rw_latch, busy, we, re, space;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] pd [16];
    logic [24:0] exp_q [$];
    logic [24:0] w_exp;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    wire logic sda_w = sda_m & ~sda_oe;
    initial forever #12.5 i_core_clk = ~i_core_clk;
    initial begin
        #1.7;
        forever #3 i_link_clk = ~i_link_clk;
    end
    function automatic logic [7:0] mdat(input logic s, input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ {s, 7'h35};
    endfunction
    tws_master M (.i_clk(i_core_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));
    // Read data is garbage outside the strobe cycle
    tws_slave #(.WR_CYCLES(600)) DUT (
        .i_core_clk(i_core_clk), .i_link_clk(i_link_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_scl(scl), .i_sda_i(sda_w), .o_sda_o(), .o_sda_oe(sda_oe),
        .i_wr_protect(prot), .o_write_enable_latch(we_latch),
        .o_register_write_latch(rw_latch), .o_busy(busy), .o_mem_we(we), .o_mem_re(re),
        .o_mem_space(space), .o_mem_addr(addr), .o_mem_wdata(wdata),
        .i_mem_rdata(re ? mdat(space, addr) : ~mdat(space, addr)));
    // Strobes launch on the rising edge; look at them mid-cycle
    always @(negedge i_core_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            conclude();
        end
        if (we === 1'b1) begin
            `CHK(exp_q.size() > 0, 1'b1)
            w_exp = exp_q.pop_front();
            `CHK({space, addr, wdata}, w_exp)
        end
    end
    task automatic hdr(input logic [7:0] sb, input logic [15:0] a);
        logic k;
        M.start();
        M.wr_byte(sb, k);
        `CHK(k, 1'b1)
        M.wr_byte(a[15:8], k);
        `CHK(k, 1'b1)
        M.wr_byte(a[7:0], k);
        `CHK(k, 1'b1)
    endtask
    task automatic wr_seq(input logic [7:0] sb, input logic [15:0] a, input int n,
                          input logic [15:0] exk);
        logic k;
        hdr(sb, a);
        for (int i = 0; i < n; i++) begin
            M.wr_byte(pd[i], k);
            `CHK(k, exk[i])
        end
        M.stop();
    endtask
    task automatic rd_cur(input logic [7:0] sb, input int n, input logic [15:0] base);
        logic k;
        logic [7:0] d;
        M.start();
        M.wr_byte(sb, k);
        `CHK(k, 1'b1)
        for (int i = 0; i < n; i++) begin
            M.rd_byte(i < n - 1, d);
            `CHK(d, mdat(sb[4], (base + i[15:0]) & 16'h07FF))
        end
        M.stop();
    endtask
    task automatic poll(input logic ex);
        logic k;
        M.start();
        M.wr_byte(8'hAE, k);
        M.stop();
        `CHK(k, ex)
    endtask
    task automatic exp_page(input logic s, input logic [15:0] a, input int n, input int psz);
        logic [7:0] last [64];
        logic [63:0] have;
        int o;
        have = 64'h0;
        for (int i = 0; i < n; i++) begin
            o = (a % psz + i) % psz;
            last[o] = pd[i];
            have[o] = 1'b1;
        end
        for (int j = 0; j < psz; j++) begin
            if (have[j]) begin
                exp_q.push_back({s, 16'(a - a % psz + j), last[j]});
            end
        end
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
            @(negedge i_core_clk);
        end
        repeat (8) @(negedge i_core_clk);
    endtask
    task automatic conclude();
        $display("compares %0d, n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        logic k;
        logic [15:0] a;
        void'($urandom(92289));
        repeat (8) @(negedge i_core_clk);
        i_rst = 1'b0;
        repeat (8) @(negedge i_core_clk);
        rd_cur(8'hAF, 3, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            a = 16'($urandom);
            a[1] = (a[7:1] == 7'h57 || a[7:1] == 7'h6F) ? ~a[1] : a[1];
            M.start();
            M.wr_byte(a[7:0], k);
            M.stop();
            `CHK(k, 1'b0)
        end
        $display("test reads and addressing done");
        pd[0] = 8'($urandom);
        wr_seq(8'hAE, 16'($urandom) & 16'h07FF, 1, 16'h0000);
        pd[0] = 8'h02;
        pd[1] = 8'h5A;
        wr_seq(8'hDE, 16'h003F, 2, 16'h0001);
        // Refused second byte idles the engine, so nothing is applied
        `CHK({rw_latch, we_latch}, 2'b00)
        wr_seq(8'hDE, 16'h003F, 1, 16'h0001);
        `CHK({rw_latch, we_latch}, 2'b01)
        pd[0] = 8'h06;
        wr_seq(8'hDE, 16'h003F, 1, 16'h0001);
        `CHK({rw_latch, we_latch}, 2'b11)
        $display("test latches done");
        for (int i = 0; i < 9; i++) begin
            pd[i] = 8'($urandom);
        end
        exp_page(1'b1, 16'h0036, 9, 8);
        wr_seq(8'hDE, 16'h0036, 9, 16'h01FF);
        poll(1'b0);
        `CHK(busy, 1'b1)
        wait_idle();
        poll(1'b1);
        `CHK(rw_latch, 1'b0)
        a = {5'h00, 5'($urandom), 6'h3E};
        exp_page(1'b0, a, 3, 64);
        wr_seq(8'hAE, a, 3, 16'h0007);
        poll(1'b0);
        wait_idle();
        $display("test page writes done");
        hdr(8'hAE, a);
        for (int i = 0; i < 4; i++) begin
            M.bit_io(1'b0, k);
        end
        M.stop();
        poll(1'b1);
        `CHK(busy, 1'b0)
        prot = 1'b1;
        wr_seq(8'hAE, 16'h0000, 1, 16'h0001);
        poll(1'b1);
        prot = 1'b0;
        $display("test abort and protect done");
        hdr(8'hAE, a);
        M.stop();
        rd_cur(8'hAF, 1, a);
        hdr(8'hAE, 16'h07FF);
        rd_cur(8'hAF, 2, 16'h07FF);
        rd_cur(8'hAF, 1, 16'h0001);
        pd[0] = 8'h00;
        wr_seq(8'hDE, 16'h003F, 1, 16'h0001);
        `CHK({rw_latch, we_latch}, 2'b00)
        `CHK(exp_q.size() == 0, 1'b1)
        $display("test random read done");
        conclude();
    end
endmodule
